/* File: pom_pkg.sv */
// Constants and register map of the pin output source multiplexer
// Functional notes
// (RQ1) Source field bits 4:2 picks receive port 0-3, device status or transmit port.
// (RQ2) Receive-port select 000 and 011 drive remote pin 0 and pin 3 values.
// (RQ3) Receive-port select 100 drives lock, 101 drives pass of that port.
// (RQ4) Receive-port select 110 drives frame valid, 111 drives line valid.
// (RQ5) Source 100 uses the device-status table through select bits 7:5.
// (RQ6) Device status select 000 drives the local value bit.
// (RQ7) Device status select 001 drives OR of lock over enabled ports.
// (RQ8) Device status select 011 drives AND of pass over enabled ports.
// (RQ9) Transmit select 000 drives AND, 001 OR, of pass over selected ports.
// (RQ10) Transmit select 010 drives frame-active, 011 drives line-active.
// (RQ11) Transmit select 100 synchronized, 101 interrupt, 111 reserved.
// (RQ12) Bit 1 holds the level driven when local value is chosen.
// (RQ13) Bit 0 enables the pin driver; cleared means driver off.
// (RQ14) Control register at index 0x12, reset value all zeros.
// (RQ15) Device status select 010 drives AND of lock over enabled ports.
// (RQ16) Device status select 100 drives frame sync; 101-111 reserved.
// (RQ17) Transmit-port table applies when source holds 110.
// (RQ18) Receive-port select 001 and 010 drive remote pin 1 and pin 2.
// (RQ19) Reserved source or select codes drive a defined low level.
package pom_pkg;
    localparam int          NUM_RX_PORTS   = 4;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL       = 8'h12;
    localparam logic [7:0]  IDX_PORT_EN    = 8'h14;
    localparam logic [7:0]  IDX_TX_SEL     = 8'h15;
    localparam logic [7:0]  IDX_PIN_STAT   = 8'h16;
    // Control register field positions
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_VAL_BIT   = 1;
    localparam int          CTRL_SRC_LSB   = 2;
    localparam int          CTRL_SEL_LSB   = 5;
    // Reset values
    localparam logic [7:0]  RST_CTRL       = 8'h00;
    localparam logic [3:0]  RST_PORT_EN    = 4'hF;
    localparam logic [3:0]  RST_TX_SEL     = 4'hF;
    // Source codes
    localparam logic [2:0]  SRC_DEV_STATUS = 3'h4;
    localparam logic [2:0]  SRC_TX_PORT    = 3'h6;
    // Select codes, receive-port table
    localparam logic [2:0]  RX_SEL_LOCK    = 3'h4;
    localparam logic [2:0]  RX_SEL_PASS    = 3'h5;
    localparam logic [2:0]  RX_SEL_FV      = 3'h6;
    localparam logic [2:0]  RX_SEL_LV      = 3'h7;
    // Select codes, device-status table
    localparam logic [2:0]  DS_SEL_LOCAL   = 3'h0;
    localparam logic [2:0]  DS_SEL_LOCK_OR = 3'h1;
    localparam logic [2:0]  DS_SEL_LOCK_AND = 3'h2;
    localparam logic [2:0]  DS_SEL_PASS_AND = 3'h3;
    localparam logic [2:0]  DS_SEL_FSYNC   = 3'h4;
    // Select codes, transmit-port table
    localparam logic [2:0]  TX_SEL_PASS_AND = 3'h0;
    localparam logic [2:0]  TX_SEL_PASS_OR = 3'h1;
    localparam logic [2:0]  TX_SEL_FRAME   = 3'h2;
    localparam logic [2:0]  TX_SEL_LINE    = 3'h3;
    localparam logic [2:0]  TX_SEL_SYNCED  = 3'h4;
    localparam logic [2:0]  TX_SEL_IRQ     = 3'h5;
endpackage

/* File: pom_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pom_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } pom_sync_state_type;

    pom_sync_state_type st_r;
    pom_sync_state_type st_nxt;

    // Elaboration check, a zero-width stage has nothing to filter
    if (WIDTH < 1) begin : g_bad_width
        $error("pom_sync: WIDTH must be at least 1");
    end

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Take a bit only once stages two and three agree
        st_nxt.q  = (st_r.s2 & st_r.s3) |
                    (st_r.q & (st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule // pom_sync
`default_nettype wire

/* File: pom_select.sv */
// Source and select decoder for the pin value
`timescale 1ns/100ps
`default_nettype none
module pom_select
    import pom_pkg::*;
(
    input  wire logic [2:0]  source,
    input  wire logic [2:0]  select,
    input  wire logic        local_value,
    input  wire logic [15:0] remote_pin,
    input  wire logic [3:0]  lock,
    input  wire logic [3:0]  pass,
    input  wire logic [3:0]  frame_valid,
    input  wire logic [3:0]  line_valid,
    input  wire logic [3:0]  port_en,
    input  wire logic [3:0]  tx_port_sel,
    input  wire logic        frame_sync_pulse,
    input  wire logic        tx_synchronized,
    input  wire logic        tx_interrupt,
    input  wire logic        tx_frame_active,
    input  wire logic        tx_line_active,
    output var  logic        value
);
    // Empty mask gives 0, so an unconfigured AND never reads as good
    function automatic logic and_masked(input logic [3:0] v,
                                        input logic [3:0] m);
        return (|m) & (&(v | ~m));
    endfunction

    function automatic logic or_masked(input logic [3:0] v,
                                       input logic [3:0] m);
        return |(v & m);
    endfunction

    logic [1:0] port;

    always_comb begin
        port  = source[1:0];
        value = 1'b0;
        // (RQ1) source group choice
        if (!source[2]) begin
            case (select)
                // (RQ3) lock and pass
                RX_SEL_LOCK: value = lock[port];
                RX_SEL_PASS: value = pass[port];
                // (RQ4) frame and line
                RX_SEL_FV:   value = frame_valid[port];
                RX_SEL_LV:   value = line_valid[port];
                // (RQ2) (RQ18) remote pin values
                default:     value = remote_pin[{port, select[1:0]}];
            endcase
        end else if (source == SRC_DEV_STATUS) begin
            // (RQ5) device status table
            case (select)
                // (RQ6) (RQ12) local value
                DS_SEL_LOCAL:    value = local_value;
                // (RQ7) lock OR
                DS_SEL_LOCK_OR:  value = or_masked(lock, port_en);
                // (RQ15) lock AND
                DS_SEL_LOCK_AND: value = and_masked(lock, port_en);
                // (RQ8) pass AND
                DS_SEL_PASS_AND: value = and_masked(pass, port_en);
                // (RQ16) frame sync
                DS_SEL_FSYNC:    value = frame_sync_pulse;
                // (RQ19) reserved low
                default:         value = 1'b0;
            endcase
        end else if (source == SRC_TX_PORT) begin
            // (RQ17) transmit port table
            case (select)
                // (RQ9) selected pass
                TX_SEL_PASS_AND: value = and_masked(pass, tx_port_sel);
                TX_SEL_PASS_OR:  value = or_masked(pass, tx_port_sel);
                // (RQ10) frame and line
                TX_SEL_FRAME:    value = tx_frame_active;
                TX_SEL_LINE:     value = tx_line_active;
                // (RQ11) sync and interrupt
                TX_SEL_SYNCED:   value = tx_synchronized;
                TX_SEL_IRQ:      value = tx_interrupt;
                default:         value = 1'b0;
            endcase
        end else begin
            // (RQ19) reserved source low
            value = 1'b0;
        end
    end
endmodule // pom_select
`default_nettype wire

/* File: pom_top.sv */
// Pin output source multiplexer with APB control registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pom_top #(
    parameter int NUM_PORTS = pom_pkg::NUM_RX_PORTS
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       pclken,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pom_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pom_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    output var  logic [pom_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic [15:0]                rx_remote_pin,
    input  wire logic [3:0]                 rx_lock,
    input  wire logic [3:0]                 rx_pass,
    input  wire logic [3:0]                 rx_frame_valid,
    input  wire logic [3:0]                 rx_line_valid,
    input  wire logic                       frame_sync_pulse,
    input  wire logic                       tx_synchronized,
    input  wire logic                       tx_interrupt,
    input  wire logic                       tx_frame_active,
    input  wire logic                       tx_line_active,
    output var  logic                       pin_out,
    output var  logic                       pin_oe
);
    import pom_pkg::*;

    localparam int SYNC_W = 37;

    typedef struct packed {
        logic [7:0]        ctrl;
        logic [3:0]        port_en;
        logic [3:0]        tx_sel;
        logic              ready;
        logic              slverr;
        logic [DATA_W-1:0] rdata;
        logic              pin_out;
        logic              pin_oe;
    } pom_top_state_type;

    pom_top_state_type st_r;
    pom_top_state_type st_nxt;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_q;
    logic              sel_value;

    // Elaboration check, the select tables are fixed at four ports
    if (NUM_PORTS != 4) begin : g_bad_ports
        $error("pom_top: tables serve four ports only");
    end

    // Word address match against a register index
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        idx);
        return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return hit(a, IDX_CTRL) | hit(a, IDX_PORT_EN) |
               hit(a, IDX_TX_SEL) | hit(a, IDX_PIN_STAT);
    endfunction

    // Status arrives from other domains, so every bit is filtered
    assign sync_in = {rx_remote_pin, rx_lock, rx_pass, rx_frame_valid,
                      rx_line_valid, frame_sync_pulse, tx_synchronized,
                      tx_interrupt, tx_frame_active, tx_line_active};

    pom_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (pclken),
        .d     (sync_in),
        .q     (sync_q)
    );

    pom_select u_select (
        .source           (st_r.ctrl[CTRL_SRC_LSB +: 3]),
        .select           (st_r.ctrl[CTRL_SEL_LSB +: 3]),
        .local_value      (st_r.ctrl[CTRL_VAL_BIT]),
        .remote_pin       (sync_q[36:21]),
        .lock             (sync_q[20:17]),
        .pass             (sync_q[16:13]),
        .frame_valid      (sync_q[12:9]),
        .line_valid       (sync_q[8:5]),
        .port_en          (st_r.port_en),
        .tx_port_sel      (st_r.tx_sel),
        .frame_sync_pulse (sync_q[4]),
        .tx_synchronized  (sync_q[3]),
        .tx_interrupt     (sync_q[2]),
        .tx_frame_active  (sync_q[1]),
        .tx_line_active   (sync_q[0]),
        .value            (sel_value)
    );

    always_comb begin
        st_nxt = st_r;
        // Setup phase: answer is ready for the first access edge
        if (psel && !penable && !st_r.ready) begin
            st_nxt.ready  = 1'b1;
            st_nxt.slverr = !mapped(paddr);
            st_nxt.rdata  = '0;
            if (!pwrite) begin
                if (hit(paddr, IDX_CTRL)) begin
                    st_nxt.rdata[7:0] = st_r.ctrl;
                end else if (hit(paddr, IDX_PORT_EN)) begin
                    st_nxt.rdata[3:0] = st_r.port_en;
                end else if (hit(paddr, IDX_TX_SEL)) begin
                    st_nxt.rdata[3:0] = st_r.tx_sel;
                end else if (hit(paddr, IDX_PIN_STAT)) begin
                    st_nxt.rdata[2:0] = {sel_value, st_r.pin_oe,
                                         st_r.pin_out};
                end
            end
        end
        // Access phase completes; writes land on this edge only
        if (psel && penable && st_r.ready) begin
            st_nxt.ready  = 1'b0;
            st_nxt.slverr = 1'b0;
            st_nxt.rdata  = '0;
            if (pwrite && pstrb[0]) begin
                // (RQ14) control register write
                if (hit(paddr, IDX_CTRL)) begin
                    st_nxt.ctrl = pwdata[7:0];
                end
                if (hit(paddr, IDX_PORT_EN)) begin
                    st_nxt.port_en = pwdata[3:0];
                end
                if (hit(paddr, IDX_TX_SEL)) begin
                    st_nxt.tx_sel = pwdata[3:0];
                end
            end
        end
        // (RQ13) driver enable
        st_nxt.pin_oe  = st_r.ctrl[CTRL_EN_BIT];
        // Disabled pin held low so the output is never undefined
        st_nxt.pin_out = st_r.ctrl[CTRL_EN_BIT] & sel_value;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // (RQ14) control reset all zeros; port enable and transmit select reset to all ones
            st_r         <= '0;
            st_r.ctrl    <= RST_CTRL;
            st_r.port_en <= RST_PORT_EN;
            st_r.tx_sel  <= RST_TX_SEL;
        end else if (pclken) begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.rdata;
    assign pready  = st_r.ready;
    assign pslverr = st_r.slverr;
    assign pin_out = st_r.pin_out;
    assign pin_oe  = st_r.pin_oe;
endmodule // pom_top
`default_nettype wire

/* File: pom_checker.sv */
// Assertion checker for the pin output multiplexer
`timescale 1ns/100ps
`default_nettype none
module pom_checker (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       pclken,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pom_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pom_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    input  wire logic [pom_pkg::DATA_W-1:0] prdata,
    input  wire logic                       pready,
    input  wire logic                       pslverr,
    input  wire logic                       pin_out,
    input  wire logic                       pin_oe
);
    import pom_pkg::*;
    logic [7:0] ctrl_r;
    logic       wr_hit;
    assign wr_hit = psel && penable && pready && pwrite && pclken
                    && pstrb[0] && paddr == 8'h48;
    // Shadow of the control word, updated on the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_r <= 8'h00;
        else if (wr_hit)
            ctrl_r <= pwdata[7:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_after_setup_a: assert property (
        psel && !penable && pclken |=> pready)
        else $error("no ready in first access cycle");
    error_on_unmapped_a: assert property (pready |->
        pslverr == !(paddr inside {8'h48, 8'h50, 8'h54, 8'h58}))
        else $error("slave error does not match address map");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside ready");
    enable_follows_bit_a: assert property (
        wr_hit |=> ##1 pin_oe == $past(pwdata[0], 2))
        else $error("driver enable does not follow bit 0");
    off_drives_low_a: assert property (!pin_oe |-> !pin_out)
        else $error("pin high while driver off");
    local_value_a: assert property ($stable(ctrl_r)
        && (ctrl_r & 8'hFD) == 8'h11 |-> pin_out == ctrl_r[1])
        else $error("pin does not carry local value bit");
    reserved_source_a: assert property (
        $stable(ctrl_r) && ctrl_r[4] && ctrl_r[2] |-> !pin_out)
        else $error("reserved source does not drive low");
    freeze_holds_pin_a: assert property (
        !pclken |=> $stable(pin_out) && $stable(pin_oe) && $stable(pready))
        else $error("outputs moved while clock enable low");
endmodule // pom_checker

bind pom_top pom_checker u_chk (.pclk(pclk), .presetn(presetn),
    .pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe(pin_oe));
`default_nettype wire

/* File: pom_pin_load.sv */
// External load on the pin, with a board pull-down
`timescale 1ns/100ps
`default_nettype none
module pom_pin_load (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output var  logic level
);
    // Undriven pin falls to the pull-down, never the last level
    assign level = pin_oe ? pin_out : 1'b0;
endmodule // pom_pin_load
`default_nettype wire

/* File: pin_output_source_mux_bench.sv */
// Self-checking bench for the pin output multiplexer
`timescale 1ns/100ps
`default_nettype none
module pin_output_source_mux_bench;
    import pom_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, er, ce;
    logic        pready, pslverr, pin_out, pin_oe, pin_level;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, lk, ps, fv, lv, sel;
    logic [15:0] rp;
    logic [4:0]  ms;
    int          n_fail, n_tests, cyc;

    // Clock enable driven so the freeze path is exercised
    pom_top dut (.pclk(pclk), .presetn(presetn), .pclken(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_remote_pin(rp), .rx_lock(lk), .rx_pass(ps),
        .rx_frame_valid(fv), .rx_line_valid(lv), .frame_sync_pulse(ms[4]),
        .tx_synchronized(ms[3]), .tx_interrupt(ms[2]),
        .tx_frame_active(ms[1]), .tx_line_active(ms[0]),
        .pin_out(pin_out), .pin_oe(pin_oe));
    pom_pin_load load (.pin_out(pin_out), .pin_oe(pin_oe),
        .level(pin_level));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input logic ee);
        apb(1'b0, a, 32'h0, 4'hF);
        chk("prdata", e, rd);
        chk("pslverr", {31'h0, ee}, {31'h0, er});
    endtask
    task automatic setin(input logic [15:0] a, input logic [3:0] b, c, d,
                         f, input logic [4:0] m);
        @(posedge pclk);
        rp <= a;
        lk <= b;
        ps <= c;
        fv <= d;
        lv <= f;
        ms <= m;
    endtask
    // Five-edge input path, so eight cycles is settled
    task automatic pin_case(input logic [7:0] c, input logic e);
        apb(1'b1, 8'h48, {24'h0, c}, 4'hF);
        repeat (8) @(posedge pclk);
        chk("pin_level", {31'h0, e}, {31'h0, pin_level});
        chk("pin_oe", {31'h0, c[0]}, {31'h0, pin_oe});
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        ce = 1'b1;
        {rp, lk, ps, fv, lv, ms} = '0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("pin_oe", 32'h0, {31'h0, pin_oe});
        rdchk(8'h48, 32'h0, 1'b0);
        rdchk(8'h50, 32'hF, 1'b0);
        rdchk(8'h54, 32'hF, 1'b0);
        rdchk(8'h4C, 32'h0, 1'b1);
        pin_case(8'hFF, 1'b0);
        apb(1'b1, 8'h48, 32'h0, 4'hE);
        rdchk(8'h48, 32'hFF, 1'b0);
        // Each port and select, driven high then inverted
        for (int v = 1; v >= 0; v--) begin
            for (int p = 0; p < 4; p++) begin
                for (int n = 0; n < 8; n++) begin
                    sel = 4'h1 << p;
                    if (v == 0)
                        setin(~(n < 4 ? 16'h1 << (4*p+n) : 16'h0),
                            n == 4 ? ~sel : 4'hF, n == 5 ? ~sel : 4'hF,
                            n == 6 ? ~sel : 4'hF, n == 7 ? ~sel : 4'hF,
                            5'h1F);
                    else
                        setin(n < 4 ? 16'h1 << (4*p+n) : 16'h0,
                            n == 4 ? sel : 4'h0, n == 5 ? sel : 4'h0,
                            n == 6 ? sel : 4'h0, n == 7 ? sel : 4'h0,
                            5'h0);
                    pin_case({3'(n), 3'(p), 2'b01}, v[0]);
                end
            end
        end
        setin(16'h0, 4'h0, 4'h0, 4'h0, 4'h0, 5'h0);
        pin_case(8'h13, 1'b1);
        pin_case(8'h11, 1'b0);
        setin(16'h0, 4'h4, 4'hF, 4'h0, 4'h0, 5'h0);
        pin_case(8'h31, 1'b1);
        // Frozen clock enable must hold the pin despite a lock drop
        @(posedge pclk);
        ce <= 1'b0;
        setin(16'h0, 4'h0, 4'hF, 4'h0, 4'h0, 5'h0);
        repeat (8) @(posedge pclk);
        chk("frozen_pin", 32'h1, {31'h0, pin_level});
        ce <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("thawed_pin", 32'h0, {31'h0, pin_level});
        pin_case(8'h51, 1'b0);
        pin_case(8'h71, 1'b1);
        setin(16'h0, 4'h1, 4'h1, 4'h0, 4'h0, 5'h10);
        apb(1'b1, 8'h50, 32'h1, 4'hF);
        pin_case(8'h51, 1'b1);
        pin_case(8'h71, 1'b1);
        pin_case(8'h91, 1'b1);
        pin_case(8'hB1, 1'b0);
        apb(1'b1, 8'h54, 32'h3, 4'hF);
        pin_case(8'h19, 1'b0);
        pin_case(8'h39, 1'b1);
        setin(16'h0, 4'h0, 4'h0, 4'h0, 4'h0, 5'h02);
        pin_case(8'h59, 1'b1);
        setin(16'h0, 4'h0, 4'h0, 4'h0, 4'h0, 5'h01);
        pin_case(8'h79, 1'b1);
        setin(16'h0, 4'h0, 4'h0, 4'h0, 4'h0, 5'h08);
        pin_case(8'h99, 1'b1);
        setin(16'h0, 4'h0, 4'h0, 4'h0, 4'h0, 5'h04);
        pin_case(8'hB9, 1'b1);
        setin(16'hFFFF, 4'hF, 4'hF, 4'hF, 4'hF, 5'h1F);
        pin_case(8'hF9, 1'b0);
        pin_case(8'h17, 1'b0);
        // Mid-run reset with the driver on
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("pin_oe", 32'h0, {31'h0, pin_oe});
        rdchk(8'h48, 32'h0, 1'b0);
        pin_case(8'h12, 1'b0);
        rdchk(8'h58, 32'h4, 1'b0);
        print_verdict();
    end
endmodule // pin_output_source_mux_bench
`default_nettype wire
